// *** verilog/svi_pkg.sv ***
// Constants for the shared-vector interrupt logic
`default_nettype none
package svi_pkg;
  localparam logic [7:0] ADDR_SRC_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INT_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam int SRC_EE_FLAG = 6;
  localparam int SRC_CV_FLAG = 4;
  localparam int SRC_EE_EN = 2;
  localparam int SRC_CV_EN = 0;
  localparam int INT_GIE = 0;
  localparam int INT_MFE = 1;
  localparam int INT_LSE = 2;
  localparam int INT_SV_FLAG = 4;
  localparam int INT_LSF = 5;
  localparam int ST_STACK_FULL = 0;
  localparam int ST_SLEEP = 1;
  localparam int ST_LOW_LEVEL = 2;
  localparam int ST_MF_PEND = 3;
  localparam int ST_LS_PEND = 4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic RST_FLAG = 1'b0;
endpackage : svi_pkg
`default_nettype wire

// *** verilog/svi_top.sv ***
// Shared-vector and low-supply interrupt logic with AHB-Lite registers
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`default_nettype none
module svi_top
  import svi_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic conv_done,
  input wire logic eeprom_write_done,
  input wire logic low_supply_detect,
  input wire logic stack_full,
  input wire logic sleep_mode,
  input wire logic return_from_irq_op,
  input wire logic return_op,
  output logic vector_call,
  output logic vector_is_low_supply,
  output logic push_pc,
  output logic pop_pc,
  output logic wake,
  output logic global_irq_enable
);
  logic conversion_done_flag;
  logic eeprom_write_done_flag;
  logic conversion_irq_enable;
  logic eeprom_irq_enable;
  logic shared_vector_request_flag;
  logic shared_vector_enable;
  logic low_supply_flag;
  logic low_supply_irq_enable;
  logic gie;
  logic wr_pend;
  logic rd_pend;
  logic [7:0] acc_addr;
  logic [2:0] ls_sync;
  logic ls_level;
  logic src_any_q;
  logic [3:0] flags_q;
  logic src_req;
  logic svc_low;
  logic svc_mf;
  logic svc_any;
  logic wr_src;
  logic wr_int;
  logic ls_rise;
  logic [3:0] flags_now;
  logic [31:0] rd_mux;

  // Address phase taken on this edge
  function automatic logic addr_taken(input logic rdy, input logic sel, input logic [1:0] trans);
    addr_taken = rdy && sel && trans == HTRANS_NONSEQ;
  endfunction : addr_taken

  // Address-phase acceptance
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      acc_addr <= 8'h00;
    end
    else if (addr_taken(hready, hsel, htrans))
    begin
      wr_pend <= hwrite;
      rd_pend <= !hwrite;
      acc_addr <= haddr[7:0];
    end
    else if (hready)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
    end
    else
    begin
      rd_pend <= 1'b0;
    end
  end

  assign wr_src = wr_pend && acc_addr == ADDR_SRC_CTRL;
  assign wr_int = wr_pend && acc_addr == ADDR_INT_CTRL;

  // Reads take one wait state so a write just before is seen
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
    end
    else if (addr_taken(hready, hsel, htrans) && !hwrite)
    begin
      hreadyout <= 1'b0;
    end
    else if (rd_pend)
    begin
      hreadyout <= 1'b1;
      hrdata <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= HRESP_OKAY;
    else
      hresp <= HRESP_OKAY;
  end

  // Read mux, unused bits and unmapped words read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (acc_addr)
      ADDR_SRC_CTRL:
      begin
        rd_mux[SRC_EE_FLAG] = eeprom_write_done_flag;
        rd_mux[SRC_CV_FLAG] = conversion_done_flag;
        rd_mux[SRC_EE_EN] = eeprom_irq_enable;
        rd_mux[SRC_CV_EN] = conversion_irq_enable;
      end
      ADDR_INT_CTRL:
      begin
        rd_mux[INT_GIE] = gie;
        rd_mux[INT_MFE] = shared_vector_enable;
        rd_mux[INT_LSE] = low_supply_irq_enable;
        rd_mux[INT_SV_FLAG] = shared_vector_request_flag;
        rd_mux[INT_LSF] = low_supply_flag;
      end
      ADDR_STATUS:
      begin
        rd_mux[ST_STACK_FULL] = stack_full;
        rd_mux[ST_SLEEP] = sleep_mode;
        rd_mux[ST_LOW_LEVEL] = ls_level;
        rd_mux[ST_MF_PEND] = shared_vector_request_flag && src_req;
        rd_mux[ST_LS_PEND] = low_supply_flag;
      end
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  // Low-supply detector level, three stages, change when last two agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ls_sync <= 3'b000;
      ls_level <= 1'b0;
    end
    else
    begin
      ls_sync <= {ls_sync[1:0], low_supply_detect};
      if (ls_sync[1] == ls_sync[2])
        ls_level <= ls_sync[2];
    end
  end

  assign ls_rise = ls_sync[1] == ls_sync[2] && ls_sync[2] && !ls_level;

  // Enables written by software
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      conversion_irq_enable <= 1'b0;
      eeprom_irq_enable <= 1'b0;
      shared_vector_enable <= 1'b0;
      low_supply_irq_enable <= 1'b0;
    end
    else
    begin
      if (wr_src)
      begin
        conversion_irq_enable <= hwdata[SRC_CV_EN];
        eeprom_irq_enable <= hwdata[SRC_EE_EN];
      end
      if (wr_int)
      begin
        shared_vector_enable <= hwdata[INT_MFE];
        low_supply_irq_enable <= hwdata[INT_LSE];
      end
    end
  end

  // Source flags: events set, software writes set or clear, set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      conversion_done_flag <= RST_FLAG;
      eeprom_write_done_flag <= RST_FLAG;
    end
    else
    begin
      if (conv_done)
        conversion_done_flag <= 1'b1;
      else if (wr_src)
        conversion_done_flag <= hwdata[SRC_CV_FLAG];
      if (eeprom_write_done)
        eeprom_write_done_flag <= 1'b1;
      else if (wr_src)
        eeprom_write_done_flag <= hwdata[SRC_EE_FLAG];
    end
  end

  // Contained requests that may reach the shared vector
  assign src_req = (conversion_done_flag && conversion_irq_enable)
    || (eeprom_write_done_flag && eeprom_irq_enable);

  // Fixed priority, low supply above shared vector
  assign svc_low = gie && low_supply_irq_enable && low_supply_flag && !stack_full;
  assign svc_mf = gie && shared_vector_enable && shared_vector_request_flag && src_req
    && !stack_full && !svc_low;
  assign svc_any = svc_low || svc_mf;

  // Shared-vector flag
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      src_any_q <= 1'b0;
      shared_vector_request_flag <= RST_FLAG;
    end
    else
    begin
      src_any_q <= conversion_done_flag || eeprom_write_done_flag;
      if ((conversion_done_flag || eeprom_write_done_flag) && !src_any_q)
        shared_vector_request_flag <= 1'b1;
      else if (svc_mf)
        shared_vector_request_flag <= 1'b0;
      else if (wr_int)
        shared_vector_request_flag <= hwdata[INT_SV_FLAG];
    end
  end

  // Low-supply flag
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      low_supply_flag <= RST_FLAG;
    else if (ls_rise)
      low_supply_flag <= 1'b1;
    else if (svc_low)
      low_supply_flag <= 1'b0;
    else if (wr_int)
      low_supply_flag <= hwdata[INT_LSF];
  end

  // Global enable: service clears, return-from-interrupt sets
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      gie <= 1'b0;
    else if (svc_any)
      gie <= 1'b0;
    else if (return_from_irq_op)
      gie <= 1'b1;
    else if (wr_int)
      gie <= hwdata[INT_GIE];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      global_irq_enable <= 1'b0;
    else if (svc_any)
      global_irq_enable <= 1'b0;
    else if (return_from_irq_op)
      global_irq_enable <= 1'b1;
    else if (wr_int)
      global_irq_enable <= hwdata[INT_GIE];
  end

  // Call strobes, one cycle after the service decision
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vector_call <= 1'b0;
      push_pc <= 1'b0;
    end
    else
    begin
      vector_call <= svc_any;
      push_pc <= svc_any;
    end
  end

  // Vector select, held until the next call
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      vector_is_low_supply <= 1'b0;
    else if (svc_any)
      vector_is_low_supply <= svc_low;
  end

  // Return strobe
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pop_pc <= 1'b0;
    else
      pop_pc <= return_from_irq_op || return_op;
  end

  // Wake-up on any flag rising while asleep
  assign flags_now = {low_supply_flag, shared_vector_request_flag, eeprom_write_done_flag, conversion_done_flag};

  // Previous flag values for edge detection
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags_q <= 4'h0;
    else
      flags_q <= flags_now;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wake <= 1'b0;
    else
      wake <= sleep_mode && |(flags_now & ~flags_q);
  end

  logic unused_ok;
  assign unused_ok = ^{haddr[31:8], hsize};
endmodule : svi_top
`default_nettype wire

// *** tb/svi_top_assertions.sv ***
// Port checks for the interrupt logic
`default_nettype none
module svi_top_assertions
  import svi_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic stack_full,
  input wire logic sleep_mode,
  input wire logic return_from_irq_op,
  input wire logic return_op,
  input wire logic vector_call,
  input wire logic push_pc,
  input wire logic pop_pc,
  input wire logic wake,
  input wire logic global_irq_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rd;
    hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  endsequence
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_read_wait: assert property (s_rd |=> s_wait)
    else $error("read wait wrong");
  chk_push_call: assert property ((push_pc == vector_call) and (vector_call |=> !vector_call))
    else $error("push and call differ");
  chk_call_gie: assert property (vector_call |-> !global_irq_enable)
    else $error("enable kept on call");
  chk_full_block: assert property (stack_full |=> !vector_call)
    else $error("call with full stack");
  chk_gie_block: assert property (!global_irq_enable |=> !vector_call)
    else $error("call with enable off");
  chk_irqret_sets: assert property (return_from_irq_op |=> pop_pc && (global_irq_enable || vector_call))
    else $error("interrupt return wrong");
  chk_ret_keeps: assert property (return_op |=> pop_pc && $stable(global_irq_enable))
    else $error("plain return wrong");
  chk_pop_cause: assert property (pop_pc |-> $past(return_op) || $past(return_from_irq_op))
    else $error("pop without return");
  chk_wake_sleep: assert property (wake |-> $past(sleep_mode))
    else $error("wake while awake");
endmodule : svi_top_assertions
bind svi_top svi_top_assertions u_chk (.*);
`default_nettype wire

// *** tb/svi_core_model.sv ***
// Program sequencer stack model
`default_nettype none
module svi_core_model
#(
  parameter int DEPTH = 2
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic push_pc,
  input wire logic pop_pc,
  output logic stack_full
);
  timeunit 1ns;
  timeprecision 1ns;
  int level;
  // Only the return address is stacked
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      level <= 0;
    else
      level <= level + int'(push_pc) - int'(pop_pc);
  // Full stack, no calls from routines
  assign stack_full = (level >= DEPTH);
endmodule : svi_core_model
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the interrupt logic
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench
  import svi_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, vector_call, vector_is_low_supply, push_pc, pop_pc, wake;
  logic global_irq_enable, stack_full, ls;
  logic [3:0] pv = 4'h0;
  logic low_supply_detect = 1'b0;
  logic sleep_mode = 1'b0;
  int err_total = 0;
  int n_compared = 0;
  int nc, nw;
  wire hready = hreadyout;
  wire conv_done = pv[0];
  wire eeprom_write_done = pv[1];
  wire return_from_irq_op = pv[2];
  wire return_op = pv[3];
  svi_top dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .conv_done(conv_done),
    .eeprom_write_done(eeprom_write_done),
    .low_supply_detect(low_supply_detect),
    .stack_full(stack_full),
    .sleep_mode(sleep_mode),
    .return_from_irq_op(return_from_irq_op),
    .return_op(return_op),
    .vector_call(vector_call),
    .vector_is_low_supply(vector_is_low_supply),
    .push_pc(push_pc),
    .pop_pc(pop_pc),
    .wake(wake),
    .global_irq_enable(global_irq_enable)
  );
  svi_core_model cm (
    .hclk(hclk),
    .hresetn(hresetn),
    .push_pc(push_pc),
    .pop_pc(pop_pc),
    .stack_full(stack_full)
  );
  always #25 hclk = ~hclk;
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    `CHK("resp", HRESP_OKAY, hresp)
  endtask : bus
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, q)
  endtask : rd
  task automatic pulse(input logic [3:0] b);
    pv <= b;
    @(posedge hclk);
    pv <= 4'h0;
  endtask : pulse
  task automatic watch(input int c);
    nc = 0;
    nw = 0;
    repeat (c)
    begin
      @(posedge hclk);
      if (vector_call === 1'b1)
      begin
        nc++;
        ls = vector_is_low_supply;
      end
      if (wake === 1'b1)
        nw++;
    end
  endtask : watch
  task automatic t_reset;
    rd("src", ADDR_SRC_CTRL, 32'h0);
    rd("int", ADDR_INT_CTRL, 32'h0);
    bus(1'b1, 8'h0c, 32'hff);
    rd("unmapped", 8'h0c, 32'h0);
  endtask : t_reset
  task automatic t_conv;
    bus(1'b1, ADDR_SRC_CTRL, 32'h1);
    bus(1'b1, ADDR_INT_CTRL, 32'h3);
    pulse(4'h1);
    watch(6);
    `CHK("conv call", 1, nc)
    `CHK("conv vec", 1'b0, ls)
    rd("conv src", ADDR_SRC_CTRL, 32'h11);
    rd("conv int", ADDR_INT_CTRL, 32'h2);
    pulse(4'h4);
    watch(3);
    `CHK("irq return gie", 1'b1, global_irq_enable)
    `CHK("irq return call", 0, nc)
    bus(1'b1, ADDR_SRC_CTRL, 32'h1);
  endtask : t_conv
  task automatic t_ee;
    pulse(4'h2);
    watch(8);
    `CHK("ee masked", 0, nc)
    rd("ee src", ADDR_SRC_CTRL, 32'h41);
    rd("ee int", ADDR_INT_CTRL, 32'h13);
    bus(1'b1, ADDR_SRC_CTRL, 32'h45);
    watch(6);
    `CHK("ee call", 1, nc)
    pulse(4'h8);
    watch(3);
    `CHK("ret gie", 1'b0, global_irq_enable)
  endtask : t_ee
  task automatic t_low;
    bus(1'b1, ADDR_SRC_CTRL, 32'h1);
    bus(1'b1, ADDR_INT_CTRL, 32'h6);
    low_supply_detect <= 1'b1;
    pulse(4'h1);
    watch(8);
    low_supply_detect <= 1'b0;
    `CHK("gie off", 0, nc)
    rd("pend int", ADDR_INT_CTRL, 32'h36);
    bus(1'b1, ADDR_INT_CTRL, 32'h37);
    watch(4);
    `CHK("ls call", 1, nc)
    `CHK("ls first", 1'b1, ls)
    rd("ls int", ADDR_INT_CTRL, 32'h16);
  endtask : t_low
  task automatic t_full;
    bus(1'b1, ADDR_INT_CTRL, 32'h17);
    watch(4);
    `CHK("shared call", 1, nc)
    bus(1'b1, ADDR_INT_CTRL, 32'h17);
    watch(8);
    `CHK("full", 0, nc)
    rd("full status", ADDR_STATUS, 32'h9);
    pulse(4'h8);
    watch(6);
    `CHK("unfull", 1, nc)
  endtask : t_full
  task automatic t_wake;
    bus(1'b1, ADDR_SRC_CTRL, 32'h40);
    watch(3);
    `CHK("awake", 0, nw)
    sleep_mode <= 1'b1;
    pulse(4'h2);
    watch(4);
    `CHK("no wake", 0, nw)
    bus(1'b1, ADDR_SRC_CTRL, 32'h0);
    pulse(4'h1);
    watch(4);
    `CHK("wake", 1'b1, nw != 0)
    rd("sleep status", ADDR_STATUS, 32'h3);
    sleep_mode <= 1'b0;
  endtask : t_wake
  task automatic test_done;
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_conv();
    t_ee();
    t_low();
    t_full();
    t_wake();
    test_done();
  end
  initial
  begin
    #100000;
    err_total++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
